//--- hw/sleep_wakeup_pkg.sv
package sleep_wakeup_pkg;

   // ****************************************************************
   // Register port and register map
   // ****************************************************************
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PORT_W = 13;
   localparam logic [1:0] REG_CONTROL = 2'h0;
   localparam logic [1:0] REG_FLAGS = 2'h1;
   localparam logic [1:0] REG_EVENTS = 2'h2;
   localparam logic [1:0] REG_MASK = 2'h3;

   // Control register fields; the reset value selects the low power crystal mode.
   localparam int unsigned CTL_MODE = 0;
   localparam int unsigned CTL_WDT_EN = 2;
   localparam int unsigned CTL_GIE = 3;
   localparam int unsigned CTL_INT_EDGE = 4;
   localparam int unsigned CTL_EXT_IE = 5;
   localparam int unsigned CTL_PORT_IE = 6;
   localparam int unsigned CTL_CMP_IE = 7;
   localparam logic [7:0] CONTROL_RST = 8'h00;

   // Flag register fields.
   localparam int unsigned FLG_PD = 0;
   localparam int unsigned FLG_TO = 1;
   localparam int unsigned FLG_EXTINT = 2;
   localparam int unsigned FLG_SLEEP = 3;

   // Event status and mask fields.
   localparam int unsigned EV_W = 4;
   localparam int unsigned EV_SLEEP = 0;
   localparam int unsigned EV_WDT = 1;
   localparam int unsigned EV_INT = 2;
   localparam int unsigned EV_MASTER_CLEAR_PIN = 3;
   localparam logic [3:0] EVENTS_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;

   // Oscillator mode codes.
   localparam logic [1:0] MODE_LP = 2'h0;
   localparam logic [1:0] MODE_XT = 2'h1;
   localparam logic [1:0] MODE_HS = 2'h2;
   localparam logic [1:0] MODE_RC = 2'h3;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam int unsigned OST_PERIODS = 1024;
   localparam int unsigned OSC_PERIOD_NS = 100;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned OST_CYCLES =
      (OST_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_RUN, ST_SLEEP, ST_START_UP, ST_POST, ST_DUMMY1, ST_DUMMY2, ST_RESET
   } state_t;

   typedef struct packed {
      state_t st;
      logic [1:0] q;
      logic iend;
      logic nop;
      logic dummy;
      logic sleeping;
      logic gie_wake;
      logic [10:0] ost;
      logic [7:0] ctrl;
      logic pd;
      logic to;
      logic extint;
      logic pin_prev;
      logic [3:0] events;
      logic [3:0] mask;
      logic irq;
      logic [7:0] rdata;
      logic osc_en;
      logic wdt_clr;
      logic dev_rst;
      logic prefetch;
      logic vec_load;
      logic [12:0] port_out;
      logic [12:0] port_oe;
   } regs_t;

endpackage

//--- hw/sleep_wakeup_control.sv
// Contract
// - Power-down is entered only by executing the sleep instruction.
// - Sleep entry clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - Port pins keep their pre-sleep drive state throughout power-down.
// - Watchdog reset is internal; master clear pin is never driven low.
// - Wake on master clear low, enabled watchdog wake-up, or enabled interrupt.
// - Master clear wake resets fully; watchdog or interrupt wake continues execution.
// - Power-down flag set at power-up, cleared by sleep; watchdog wake clears timeout flag.
// - The instruction after sleep is prefetched while sleep executes.
// - Interrupt wakes only if its enable is set, regardless of global enable.
// - Interrupt wake with global enable clear continues in line.
// - Interrupt wake with global enable set runs next instruction then vectors.
// - Already pending enabled interrupt makes sleep complete and wake at once.
// - Watchdog is cleared on every wake from power-down.
// - Crystal modes wait 1024 oscillator periods on wake; resistor-capacitor mode does not. The code skips the wait on master clear wake.
// - An instruction cycle is four oscillator periods; normal instructions take one.
// - Branches or true conditional tests take two cycles, the second a no-operation.
module sleep_wakeup_control
   import sleep_wakeup_pkg::*;
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic nrst_i,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // Core instruction status.
   input wire logic sleep_exec_i,
   input wire logic branch_i,
   // Wake sources.
   input wire logic master_clear_pin_i,
   input wire logic watchdog_timeout_i,
   input wire logic external_interrupt_pin_i,
   input wire logic port_change_flag_i,
   input wire logic comparator_flag_i,
   // Port drive from the core.
   input wire logic [PORT_W-1:0] port_out_i,
   input wire logic [PORT_W-1:0] port_oe_i,
   // Port pins as driven.
   output logic [PORT_W-1:0] port_out_o,
   output logic [PORT_W-1:0] port_oe_o,
   // Master clear pin drive.
   output logic master_clear_out_o,
   output logic master_clear_oe_o,
   // Core sequencing.
   output logic [1:0] q_phase_o,
   output logic instr_end_o,
   output logic execute_nop_o,
   output logic dummy_cycle_o,
   output logic prefetch_o,
   output logic vector_load_o,
   output logic [12:0] vector_addr_o,
   output logic device_reset_o,
   // Power status.
   output logic sleeping_o,
   output logic osc_driver_en_o,
   output logic watchdog_clear_o,
   output logic power_down_flag_o,
   output logic timeout_flag_o,
   output logic external_int_flag_o,
   output logic irq_o
);

   // ****************************************************************
   // Reset release
   // ****************************************************************

   // The reset is released through two flip-flops so that its removal is synchronous.
   logic [1:0] rst_sync_ff;
   logic rst_n;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   // ****************************************************************
   // State update
   // ****************************************************************

   regs_t r_ff;
   regs_t nxt_r;
   logic edge_seen;
   logic wake_int;
   logic crystal;
   logic wdt_en;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   logic clr_extint;

   // All next-state logic lives here; the register copy below holds everything.
   always_comb begin
      nxt_r = r_ff;
      ev_set = 4'h0;
      ev_clr = 4'h0;
      clr_extint = 1'b0;
      nxt_r.wdt_clr = 1'b0;
      nxt_r.prefetch = 1'b0;
      nxt_r.vec_load = 1'b0;
      nxt_r.dev_rst = 1'b0;
      nxt_r.rdata = 8'h00;
      wdt_en = r_ff.ctrl[CTL_WDT_EN];
      crystal = (r_ff.ctrl[CTL_MODE +: 2] != MODE_RC);

      // The valid edge follows the selected polarity; the flag is sticky.
      edge_seen = r_ff.ctrl[CTL_INT_EDGE] ?
                  (external_interrupt_pin_i && !r_ff.pin_prev) :
                  (!external_interrupt_pin_i && r_ff.pin_prev);
      nxt_r.pin_prev = external_interrupt_pin_i;

      // Only individually enabled sources may wake, the global enable is ignored.
      wake_int = ((r_ff.extint || edge_seen) && r_ff.ctrl[CTL_EXT_IE]) ||
                 (port_change_flag_i && r_ff.ctrl[CTL_PORT_IE]) ||
                 (comparator_flag_i && r_ff.ctrl[CTL_CMP_IE]);

      // Register writes and reads.
      if (reg_write_i) begin
         case (reg_addr_i)
            REG_CONTROL: nxt_r.ctrl = reg_wdata_i;
            REG_FLAGS: clr_extint = reg_wdata_i[FLG_EXTINT];
            REG_EVENTS: ev_clr = reg_wdata_i[EV_W-1:0];
            REG_MASK: nxt_r.mask = reg_wdata_i[EV_W-1:0];
            default: nxt_r.mask = r_ff.mask;
         endcase
      end
      if (reg_read_i) begin
         case (reg_addr_i)
            REG_CONTROL: nxt_r.rdata = r_ff.ctrl;
            REG_FLAGS: nxt_r.rdata = {4'h0, r_ff.sleeping, r_ff.extint, r_ff.to, r_ff.pd};
            REG_EVENTS: nxt_r.rdata = {4'h0, r_ff.events};
            REG_MASK: nxt_r.rdata = {4'h0, r_ff.mask};
            default: nxt_r.rdata = 8'h00;
         endcase
      end

      // A new edge wins over a clear in the same cycle.
      nxt_r.extint = (r_ff.extint && !clr_extint) || edge_seen;

      // Sequencer.
      case (r_ff.st)
         ST_RUN: begin
            nxt_r.q = r_ff.q + 2'h1;
            if (watchdog_timeout_i && wdt_en) begin
               // Internal reset only; the master clear pin stays undriven.
               nxt_r.dev_rst = 1'b1;
               nxt_r.to = 1'b0;
               nxt_r.q = 2'h0;
               nxt_r.nop = 1'b0;
            end else if (r_ff.q == Q_LAST) begin
               if (r_ff.nop) begin
                  nxt_r.nop = 1'b0;
               end else if (sleep_exec_i) begin
                  nxt_r.pd = 1'b0;
                  nxt_r.to = 1'b1;
                  nxt_r.wdt_clr = 1'b1;
                  nxt_r.prefetch = 1'b1;
                  ev_set[EV_SLEEP] = 1'b1;
                  if (wake_int) begin
                     // Sleep completes, but the oscillator never stops.
                     nxt_r.st = ST_POST;
                     nxt_r.gie_wake = r_ff.ctrl[CTL_GIE];
                     ev_set[EV_INT] = 1'b1;
                  end else begin
                     nxt_r.st = ST_SLEEP;
                     nxt_r.osc_en = 1'b0;
                  end
               end else begin
                  nxt_r.nop = branch_i;
               end
            end
         end
         ST_SLEEP: begin
            if ((watchdog_timeout_i && wdt_en) || wake_int) begin
               nxt_r.wdt_clr = 1'b1;
               nxt_r.osc_en = 1'b1;
               nxt_r.ost = 11'h000;
               nxt_r.q = 2'h0;
               nxt_r.st = crystal ? ST_START_UP : ST_POST;
               if (watchdog_timeout_i && wdt_en) begin
                  nxt_r.to = 1'b0;
                  nxt_r.gie_wake = 1'b0;
                  ev_set[EV_WDT] = 1'b1;
               end else begin
                  nxt_r.gie_wake = r_ff.ctrl[CTL_GIE];
                  ev_set[EV_INT] = 1'b1;
               end
            end
         end
         ST_START_UP: begin
            nxt_r.ost = r_ff.ost + 11'h001;
            if (r_ff.ost == OST_LAST) begin
               nxt_r.st = ST_POST;
            end
         end
         ST_POST: begin
            // The prefetched instruction executes before any vectoring.
            nxt_r.q = r_ff.q + 2'h1;
            if (r_ff.q == Q_LAST) begin
               nxt_r.st = r_ff.gie_wake ? ST_DUMMY1 : ST_RUN;
            end
         end
         ST_DUMMY1: begin
            nxt_r.q = r_ff.q + 2'h1;
            if (r_ff.q == Q_LAST) begin
               nxt_r.st = ST_DUMMY2;
            end
         end
         ST_DUMMY2: begin
            nxt_r.q = r_ff.q + 2'h1;
            if (r_ff.q == Q_LAST) begin
               nxt_r.st = ST_RUN;
               nxt_r.vec_load = 1'b1;
            end
         end
         ST_RESET: begin
            nxt_r.dev_rst = 1'b1;
            nxt_r.q = 2'h0;
            if (master_clear_pin_i) begin
               nxt_r.st = ST_RUN;
            end
         end
         default: begin
            nxt_r.st = ST_RUN;
         end
      endcase

      // Master clear low overrides everything and is a full reset.
      if (!master_clear_pin_i) begin
         nxt_r.st = ST_RESET;
         nxt_r.dev_rst = 1'b1;
         nxt_r.osc_en = 1'b1;
         nxt_r.q = 2'h0;
         nxt_r.nop = 1'b0;
         nxt_r.gie_wake = 1'b0;
         if (r_ff.st == ST_SLEEP) begin
            nxt_r.wdt_clr = 1'b1;
            ev_set[EV_MASTER_CLEAR_PIN] = 1'b1;
         end
      end

      // Pins follow the core until sleep, then freeze.
      if (r_ff.st != ST_SLEEP) begin
         nxt_r.port_out = port_out_i;
         nxt_r.port_oe = port_oe_i;
      end

      // Event status bits: a new event wins over a clear in the same cycle.
      nxt_r.events = (r_ff.events & ~ev_clr) | ev_set;
      nxt_r.irq = |(nxt_r.events & nxt_r.mask);

      // Decoded outputs are registered here so every port except the master clear drive and the vector address comes from a flip-flop.
      nxt_r.sleeping = (nxt_r.st == ST_SLEEP);
      nxt_r.dummy = (nxt_r.st == ST_DUMMY1) || (nxt_r.st == ST_DUMMY2);
      nxt_r.iend = (nxt_r.q == Q_LAST) && (nxt_r.st != ST_SLEEP) &&
                   (nxt_r.st != ST_START_UP) && (nxt_r.st != ST_RESET);
   end

   // Power-up values: power-down and timeout flags both read set.
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         r_ff <= '{st: ST_RUN, q: 2'h0, iend: 1'b0, nop: 1'b0, dummy: 1'b0,
                   sleeping: 1'b0, gie_wake: 1'b0, ost: 11'h000, ctrl: CONTROL_RST,
                   pd: 1'b1, to: 1'b1, extint: 1'b0, pin_prev: 1'b0,
                   events: EVENTS_RST, mask: MASK_RST, irq: 1'b0, rdata: 8'h00,
                   osc_en: 1'b1, wdt_clr: 1'b0, dev_rst: 1'b0, prefetch: 1'b0,
                   vec_load: 1'b0, port_out: 13'h0000, port_oe: 13'h0000};
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output except the master clear drive and the vector address is a field of the register copy.
   assign reg_rdata_o = r_ff.rdata;
   assign port_out_o = r_ff.port_out;
   assign port_oe_o = r_ff.port_oe;
   assign master_clear_out_o = 1'b0;
   assign master_clear_oe_o = 1'b0;
   assign q_phase_o = r_ff.q;
   assign instr_end_o = r_ff.iend;
   assign execute_nop_o = r_ff.nop;
   assign dummy_cycle_o = r_ff.dummy;
   assign prefetch_o = r_ff.prefetch;
   assign vector_load_o = r_ff.vec_load;
   assign vector_addr_o = VECTOR_ADDR;
   assign device_reset_o = r_ff.dev_rst;
   assign sleeping_o = r_ff.sleeping;
   assign osc_driver_en_o = r_ff.osc_en;
   assign watchdog_clear_o = r_ff.wdt_clr;
   assign power_down_flag_o = r_ff.pd;
   assign timeout_flag_o = r_ff.to;
   assign external_int_flag_o = r_ff.extint;
   assign irq_o = r_ff.irq;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n);

   sleep_only_a: assert property ($rose(sleeping_o) |-> $past(sleep_exec_i))
      else $error("Sleep entered without the sleep instruction.");
   sleep_entry_a: assert property ($rose(sleeping_o) |->
      (!power_down_flag_o && timeout_flag_o && watchdog_clear_o && !osc_driver_en_o))
      else $error("Sleep entry did not update flags, watchdog and oscillator.");
   pins_hold_a: assert property (sleeping_o && $past(sleeping_o) |->
      $stable(port_out_o) && $stable(port_oe_o))
      else $error("Port drive changed during sleep.");
   master_clear_pin_undriven_a: assert property (!master_clear_oe_o)
      else $error("Master clear pin is driven.");
   master_clear_pin_reset_a: assert property (!master_clear_pin_i |=> device_reset_o ##1
      (device_reset_o || master_clear_pin_i))
      else $error("Master clear low did not reset the device.");
   wdt_wake_a: assert property (sleeping_o && wdt_en && watchdog_timeout_i &&
      master_clear_pin_i |=> !timeout_flag_o && !sleeping_o && !device_reset_o)
      else $error("Watchdog wake mishandled.");
   int_wake_a: assert property (sleeping_o && wake_int && master_clear_pin_i |=>
      !sleeping_o && !device_reset_o)
      else $error("Enabled interrupt did not wake.");
   wake_clear_a: assert property ($fell(sleeping_o) |-> watchdog_clear_o)
      else $error("Watchdog not cleared on wake.");
   ost_wait_a: assert property (r_ff.st == ST_START_UP && r_ff.ost != OST_LAST &&
      master_clear_pin_i |=> r_ff.st == ST_START_UP)
      else $error("Start-up delay cut short.");
   rc_skip_a: assert property ($fell(sleeping_o) && r_ff.st != ST_RESET &&
      r_ff.ctrl[CTL_MODE +: 2] == MODE_RC |-> r_ff.st == ST_POST)
      else $error("Start-up delay applied in RC mode.");
   pend_wake_a: assert property (r_ff.st == ST_RUN && r_ff.q == Q_LAST && !r_ff.nop &&
      sleep_exec_i && wake_int && !(watchdog_timeout_i && wdt_en) && master_clear_pin_i
      |=> r_ff.st == ST_POST && !sleeping_o)
      else $error("Pending interrupt did not cancel sleep.");
   nop_cycle_a: assert property (r_ff.st == ST_RUN && r_ff.q == Q_LAST && !r_ff.nop &&
      branch_i && !sleep_exec_i && !watchdog_timeout_i && master_clear_pin_i
      |=> execute_nop_o [*4])
      else $error("Branch second cycle is not a no-operation.");
   vector_a: assert property (disable iff (!rst_n || !master_clear_pin_i)
      $rose(dummy_cycle_o) |-> dummy_cycle_o [*8] ##1 vector_load_o)
      else $error("Vector fetch not after two dummy cycles.");
   extint_set_a: assert property (edge_seen |=> external_int_flag_o)
      else $error("External edge lost.");

   // Prefetch, stopped oscillator, phase stepping and in-line resumption.
   prefetch_a: assert property ($rose(sleeping_o) |-> prefetch_o)
      else $error("Sleep entry without prefetch of the next instruction.");
   osc_off_a: assert property (sleeping_o |-> !osc_driver_en_o)
      else $error("Oscillator driver running during sleep.");
   quarter_step_a: assert property (r_ff.st == ST_RUN && !watchdog_timeout_i &&
      master_clear_pin_i |=> q_phase_o == $past(q_phase_o) + 2'h1)
      else $error("Quarter phase did not advance.");
   inline_wake_a: assert property (r_ff.st == ST_POST && r_ff.q == Q_LAST && !r_ff.gie_wake &&
      master_clear_pin_i |=> r_ff.st == ST_RUN && !dummy_cycle_o)
      else $error("In-line wake did not resume in run.");

   wake_int_c: cover property ($fell(sleeping_o) && r_ff.st == ST_START_UP && r_ff.gie_wake);
   wake_wdt_c: cover property (sleeping_o ##1 !sleeping_o && !timeout_flag_o);
   wake_master_clear_pin_c: cover property (sleeping_o ##1 r_ff.st == ST_RESET);
   pend_c: cover property ($rose(prefetch_o) && r_ff.st == ST_POST);
   inline_c: cover property (r_ff.st == ST_POST && !r_ff.gie_wake && r_ff.q == Q_LAST);

endmodule

//--- verif/wake_source_model.sv
// ****************************************************************
// Reset pin driver and interrupt sources beside the sleep block
// ****************************************************************
module wake_source_model (
   // Clock.
   input wire logic clock_i,
   // Wake sources towards the block.
   output logic master_clear_pin_o,
   output logic watchdog_timeout_o,
   output logic external_interrupt_pin_o,
   output logic port_change_flag_o,
   output logic comparator_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // The reset pin idles high so that sleep is never cut short by accident.
   initial begin
      master_clear_pin_o = 1'b1;
      watchdog_timeout_o = 1'b0;
      external_interrupt_pin_o = 1'b0;
      port_change_flag_o = 1'b0;
      comparator_flag_o = 1'b0;
   end

   // One-cycle expiry pulse, as the watchdog gives it.
   task automatic pulse_wdt();
      @(posedge clock_i) watchdog_timeout_o <= 1'b1;
      @(posedge clock_i) watchdog_timeout_o <= 1'b0;
   endtask

   // Level changes, each launched just after a rising edge.
   task automatic set_ext(input logic v);
      @(posedge clock_i) external_interrupt_pin_o <= v;
   endtask

   task automatic set_master_clear_pin(input logic v);
      @(posedge clock_i) master_clear_pin_o <= v;
   endtask

   task automatic set_flags(input logic pc, input logic cmp);
      @(posedge clock_i) port_change_flag_o <= pc;
      comparator_flag_o <= cmp;
   endtask
endmodule

//--- verif/test_sleep_wakeup_control.sv
// ****************************************************************
// Self-checking bench for the sleep and wake-up controller
// ****************************************************************
module test_sleep_wakeup_control;
   timeunit 1ns;
   timeprecision 1ns;
   import sleep_wakeup_pkg::*;

   logic clock_i = 1'b0;
   logic nrst_i, reg_write, reg_read, sleep_exec, branch;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [12:0] port_out, port_oe, pout, poe, vaddr;
   logic master_clear_pin, wdt, ext, pchg, cmp, master_clear_pin_oe, nop, pref, vload, dres;
   logic sleeping, osc_en, wclr, pd, to, extf, irq, dummy, iend, master_clear_pin_out;
   logic [1:0] q;
   int n_mismatch = 0;
   int check_count = 0;
   int n;

   // Free-running 10 MHz clock.
   always #50 clock_i = ~clock_i;

   sleep_wakeup_control sleep_wakeup_control_inst (
      .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata),
      .sleep_exec_i(sleep_exec), .branch_i(branch), .master_clear_pin_i(master_clear_pin),
      .watchdog_timeout_i(wdt), .external_interrupt_pin_i(ext),
      .port_change_flag_i(pchg), .comparator_flag_i(cmp), .port_out_i(port_out),
      .port_oe_i(port_oe), .port_out_o(pout), .port_oe_o(poe),
      .master_clear_out_o(master_clear_pin_out), .master_clear_oe_o(master_clear_pin_oe), .q_phase_o(q),
      .instr_end_o(iend), .execute_nop_o(nop), .dummy_cycle_o(dummy), .prefetch_o(pref),
      .vector_load_o(vload), .vector_addr_o(vaddr), .device_reset_o(dres),
      .sleeping_o(sleeping), .osc_driver_en_o(osc_en), .watchdog_clear_o(wclr),
      .power_down_flag_o(pd), .timeout_flag_o(to), .external_int_flag_o(extf),
      .irq_o(irq));

   wake_source_model wake_source_model_inst (
      .clock_i(clock_i), .master_clear_pin_o(master_clear_pin), .watchdog_timeout_o(wdt),
      .external_interrupt_pin_o(ext), .port_change_flag_o(pchg),
      .comparator_flag_o(cmp));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Register port: one-cycle strobes, read data only in the following cycle.
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock_i) reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock_i) reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock_i) reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock_i) reg_read <= 1'b0;
      @(negedge clock_i) d = reg_rdata;
   endtask

   // Returns on the edge that starts the last quarter of an instruction cycle.
   task automatic at_q3();
      n = 0;
      do begin
         @(negedge clock_i) n++;
      end while (q !== 2'h2 && n < 8);
      @(posedge clock_i);
   endtask

   task automatic do_sleep();
      at_q3();
      sleep_exec <= 1'b1;
      @(posedge clock_i) sleep_exec <= 1'b0;
      @(negedge clock_i);
   endtask

   // Sleep entry, frozen pins, watchdog wake and the event interrupt.
   task automatic sc_wdt_wake();
      wr(REG_CONTROL, 8'h07);
      port_out <= 13'h1A5A;
      port_oe <= 13'h0F0F;
      do_sleep();
      chk(sleeping, 1);
      chk({osc_en, pd, to, wclr}, 4'h3);
      chk(pref, 1);
      @(posedge clock_i) port_out <= 13'h0555;
      port_oe <= 13'h0000;
      repeat (2) @(negedge clock_i);
      chk(pout, 13'h1A5A);
      chk(poe, 13'h0F0F);
      wake_source_model_inst.pulse_wdt();
      @(negedge clock_i);
      chk({sleeping, to, vload}, 3'h0);
      chk(wclr, 1);
      wr(REG_MASK, 8'h03);
      @(negedge clock_i) chk(irq, 1);
      wr(REG_EVENTS, 8'h03);
      @(negedge clock_i) chk(irq, 0);
   endtask

   // Edge wake in crystal modes: vectoring with the global enable, in line without it.
   // The second pass never vectors, so its wait runs to the end of a fixed window.
   task automatic sc_int_vector();
      int nd;
      for (int i = 0; i < 2; i++) begin
         wr(REG_CONTROL, (i == 0) ? 8'h39 : 8'h22);
         do_sleep();
         wake_source_model_inst.set_ext(i == 0);
         n = 0;
         while (sleeping !== 1'b0 && n < 20) begin
            @(negedge clock_i) n++;
         end
         n = 0;
         nd = 0;
         while (vload !== 1'b1 && n < 1100) begin
            @(negedge clock_i) n++;
            nd += dummy;
         end
         chk(n, (i == 0) ? 1036 : 1100);
         chk(nd, (i == 0) ? 8 : 0);
         chk(extf, 1);
         wr(REG_FLAGS, 8'h04);
      end
      chk(vaddr, 13'h0004);
   endtask

   // A disabled source leaves the device asleep; the reset pin then wakes it.
   task automatic sc_master_clear_pin_wake();
      wr(REG_CONTROL, 8'h13);
      wake_source_model_inst.set_ext(1'b0);
      do_sleep();
      wake_source_model_inst.set_ext(1'b1);
      repeat (10) @(negedge clock_i);
      chk(sleeping, 1);
      wake_source_model_inst.set_master_clear_pin(1'b0);
      repeat (2) @(negedge clock_i);
      chk({dres, sleeping}, 2'h2);
      chk({master_clear_pin_out, master_clear_pin_oe}, 2'h0);
      wake_source_model_inst.set_master_clear_pin(1'b1);
      repeat (4) @(negedge clock_i);
      rd(REG_EVENTS, v);
      chk(v[EV_MASTER_CLEAR_PIN], 1);
   endtask

   // A source already pending and enabled cancels sleep at once.
   task automatic sc_pending();
      for (int i = 0; i < 2; i++) begin
         wr(REG_CONTROL, (i == 0) ? 8'h43 : 8'h83);
         wake_source_model_inst.set_flags(i == 0, i == 1);
         do_sleep();
         chk(sleeping, 0);
         chk({pref, pd}, 2'h2);
         wake_source_model_inst.set_flags(1'b0, 1'b0);
      end
   endtask

   // A taken branch is followed by one full no-operation cycle.
   task automatic sc_branch();
      // A cancelled sleep leaves a post cycle running, which ignores the branch input.
      repeat (4) @(negedge clock_i);
      at_q3();
      branch <= 1'b1;
      @(posedge clock_i) branch <= 1'b0;
      repeat (4) begin
         @(negedge clock_i) chk(nop, 1);
      end
      chk({iend, q}, 3'h7);
      @(negedge clock_i) chk(nop, 0);
   endtask

   // Main sequence.
   initial begin
      {nrst_i, reg_write, reg_read, sleep_exec, branch} = '0;
      {reg_addr, reg_wdata, port_out, port_oe} = '0;
      repeat (8) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      @(negedge clock_i) chk({pd, to, osc_en, sleeping}, 4'hE);
      rd(REG_CONTROL, v);
      chk(v, CONTROL_RST);
      rd(REG_FLAGS, v);
      chk(v, 8'h03);
      rd(REG_EVENTS, v);
      chk(v, 8'h00);
      sc_wdt_wake();
      sc_int_vector();
      sc_master_clear_pin_wake();
      sc_pending();
      sc_branch();
      report_and_stop();
   end

   // Watchdog against a hung wait; the whole run needs about 230 us.
   initial begin
      #1_000_000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
